// ### src/ssc_pkg.sv
package ssc_pkg;
   // address and lane geometry
   localparam int ADDR_W     = 20;
   localparam int LANE_N     = 2;
   localparam int LANE_DQ_W  = 8;
   localparam int LANE_W     = 9;
   localparam int DQ_W       = 16;
   localparam int BURST_W    = 2;
   localparam int BUF_DEPTH  = 2;
   // clock figures
   localparam int CLK_MHZ    = 50;
   localparam int CLK_NS     = 1000 / CLK_MHZ;
   // burst order strap levels
   localparam logic ORDER_LINEAR = 1'b0;
   localparam logic ORDER_INTLV  = 1'b1;
   // reset, step and full-count values
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
   localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
   localparam logic [1:0]         CNT_ZERO  = 2'h0;
   localparam logic [1:0]         CNT_ONE   = 2'h1;
   localparam logic [1:0]         CNT_FULL  = 2'h2;

   typedef enum logic [1:0] {
      SSC_IDLE  = 2'b00,
      SSC_READ  = 2'b01,
      SSC_WRITE = 2'b10
   } ssc_op_t;
endpackage : ssc_pkg

// ### src/ssc_mem.sv
`timescale 1ns/1ps
module ssc_mem #(
   parameter int AW     = 20,
   parameter int LW     = 9,
   parameter int LANES  = 2
) (
   // clock
   input  wire logic                  mclk_in,
   // write port
   input  wire logic [LANES-1:0]      wr_lane_in,
   input  wire logic [AW-1:0]         wr_addr_in,
   input  wire logic [LANES*LW-1:0]   wr_data_in,
   // read port
   input  wire logic                  rd_en_in,
   input  wire logic [AW-1:0]         rd_addr_in,
   output logic      [LANES*LW-1:0]   rd_data_out
);
   logic [LANES*LW-1:0] store [0:(1<<AW)-1];

   initial begin
      if (AW < 1 || AW > 24 || LW < 1 || LANES < 1) begin
         $error("ssc_mem: geometry out of range");
      end
   end

   // one process owns the array; lanes are merged in a loop
   always_ff @(posedge mclk_in) begin
      for (int g = 0; g < LANES; g++) begin
         if (wr_lane_in[g]) begin
            store[wr_addr_in][g*LW +: LW] <= wr_data_in[g*LW +: LW];
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rd_en_in) begin
         rd_data_out <= store[rd_addr_in];
      end
   end
endmodule : ssc_mem

// ### src/ssc_ctrl.sv
// Operation
// - qualified edges capture address, select one location
// - low two address bits seed burst base, counter clears
// - lane selects write only with write strobe
// - write strobe sampled only on qualified edges
// - advance input high steps the burst counter
// - advance input low loads a new address
// - unqualified edges capture nothing, change nothing
// - selected only when first,third low, second high
// - output enable low drives pins, high floats
// - pins float during write data phase
// - pins float deselected and first clock after
// - clock qualify stretches cycle, does not deselect
// - read drives data addressed at previous edge
// - burst strap low linear, high interleaved
`timescale 1ns/1ps
module ssc_ctrl
   import ssc_pkg::*;
#(
   parameter int AW = ssc_pkg::ADDR_W
) (
   // clock, reset, enable
   input  wire logic                          mclk_in,
   input  wire logic                          sys_rst_in,
   input  wire logic                          clk_en_in,
   // command pins
   input  wire logic                          clock_qualify_n_in,
   input  wire logic [AW-1:0]                 addr_in,
   input  wire logic [ssc_pkg::LANE_N-1:0]    lane_write_select_n_in,
   input  wire logic                          write_strobe_n_in,
   input  wire logic                          advance_or_load_in,
   input  wire logic                          select_low_first_n_in,
   input  wire logic                          select_high_second_in,
   input  wire logic                          select_low_third_n_in,
   input  wire logic                          output_enable_n_in,
   input  wire logic                          burst_order_in,
   // data pins
   input  wire logic [ssc_pkg::DQ_W-1:0]      dq_in,
   input  wire logic [ssc_pkg::LANE_N-1:0]    bidir_parity_pins_in,
   output logic      [ssc_pkg::DQ_W-1:0]      dq_out,
   output logic      [ssc_pkg::LANE_N-1:0]    bidir_parity_pins_out,
   output logic                               dq_oe_n_out,
   // write buffer status
   output logic                               wbuf_ready_out
);
   import ssc_pkg::*;

   localparam int EW = AW + LANE_N + LANE_N * LANE_W;

   initial begin
      if (AW < BURST_W + 1 || AW > 24) begin
         $error("ssc_ctrl: address width out of range");
      end
   end

   function automatic logic [BURST_W-1:0] burst_low(input logic order,
                                                    input logic [BURST_W-1:0] base,
                                                    input logic [BURST_W-1:0] cnt);
      burst_low = (order == ORDER_LINEAR) ? base + cnt : base ^ cnt;
   endfunction : burst_low

   function automatic logic burst_burst_strap(input logic lvl);
      burst_burst_strap = lvl ? ORDER_INTLV : ORDER_LINEAR;
   endfunction : burst_burst_strap

   logic qual;
   logic sel_now;
   assign qual    = clk_en_in & ~clock_qualify_n_in;
   assign sel_now = ~select_low_first_n_in & select_high_second_in
                    & ~select_low_third_n_in;

   // command state
   ssc_op_t              op_q, op_d;
   logic [AW-1:0]        addr_q, addr_d;
   logic [BURST_W-1:0]   base_q, base_d;
   logic [BURST_W-1:0]   cnt_q, cnt_d;
   logic [LANE_N-1:0]    lanes_q, lanes_d;
   logic                 order_q, order_d;
   logic                 drv_q, drv_d;
   logic                 rd_en;

   always_comb begin
      op_d    = op_q;
      addr_d  = addr_q;
      base_d  = base_q;
      cnt_d   = cnt_q;
      lanes_d = lanes_q;
      order_d = order_q;
      drv_d   = drv_q;
      rd_en   = 1'b0;
      if (sys_rst_in) begin
         order_d = burst_burst_strap(burst_order_in);
      end else if (qual) begin
         if (!advance_or_load_in) begin
            addr_d = addr_in;
            base_d = addr_in[BURST_W-1:0];
            cnt_d  = BURST_RST;
            if (!sel_now) begin
               op_d = SSC_IDLE;
            end else if (!write_strobe_n_in) begin
               op_d = SSC_WRITE;
            end else begin
               op_d = SSC_READ;
            end
         end else begin
            cnt_d  = cnt_q + BURST_ONE;
            addr_d = {addr_q[AW-1:BURST_W], burst_low(order_q, base_q, cnt_d)};
         end
         lanes_d = ~lane_write_select_n_in;
         rd_en   = (op_d == SSC_READ);
         // float when deselected, on first clock after, and in write data
         drv_d   = (op_d == SSC_READ) && (op_q != SSC_IDLE)
                   && !output_enable_n_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         op_q        <= SSC_IDLE;
         addr_q      <= '0;
         base_q      <= BURST_RST;
         cnt_q       <= BURST_RST;
         lanes_q     <= '0;
         drv_q       <= 1'b0;
         dq_oe_n_out <= 1'b1;
      end else begin
         op_q        <= op_d;
         addr_q      <= addr_d;
         base_q      <= base_d;
         cnt_q       <= cnt_d;
         lanes_q     <= lanes_d;
         drv_q       <= drv_d;
         dq_oe_n_out <= ~drv_d;
      end
      order_q <= order_d;
   end

   // two-entry write buffer between data capture and the array
   logic [EW-1:0] buf_q [0:BUF_DEPTH-1];
   logic [EW-1:0] buf_d [0:BUF_DEPTH-1];
   logic          wp_q, wp_d, rp_q, rp_d;
   logic [1:0]    cnt_b_q, cnt_b_d;
   logic          push, pop;
   logic [EW-1:0] push_word;
   logic [LANE_N*LANE_W-1:0] wr_data;

   generate
      for (genvar i = 0; i < LANE_N; i++) begin : g_pack
         assign wr_data[i*LANE_W +: LANE_W] =
            {bidir_parity_pins_in[i], dq_in[i*LANE_DQ_W +: LANE_DQ_W]};
      end
   endgenerate

   assign push      = qual && !sys_rst_in && (op_q == SSC_WRITE);
   assign pop       = qual && !sys_rst_in && (cnt_b_q != CNT_ZERO);
   assign push_word = {addr_q, lanes_q, wr_data};

   always_comb begin
      buf_d   = buf_q;
      wp_d    = wp_q;
      rp_d    = rp_q;
      cnt_b_d = cnt_b_q;
      if (push && (cnt_b_q != CNT_FULL || pop)) begin
         buf_d[wp_q] = push_word;
         wp_d        = ~wp_q;
      end
      if (pop) begin
         rp_d = ~rp_q;
      end
      if (push && !pop && cnt_b_q != CNT_FULL) begin
         cnt_b_d = cnt_b_q + CNT_ONE;
      end else if (pop && !push) begin
         cnt_b_d = cnt_b_q - CNT_ONE;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         wp_q    <= 1'b0;
         rp_q    <= 1'b0;
         cnt_b_q <= CNT_ZERO;
         wbuf_ready_out <= 1'b1;
      end else begin
         wp_q    <= wp_d;
         rp_q    <= rp_d;
         cnt_b_q <= cnt_b_d;
         wbuf_ready_out <= (cnt_b_d != CNT_FULL);
      end
      buf_q <= buf_d;
   end

   // array access; lane bits only count on an edge where the buffer pops an entry
   logic [EW-1:0]            head;
   logic [LANE_N-1:0]        mem_lane;
   logic [LANE_N*LANE_W-1:0] rd_data;
   assign head     = buf_q[rp_q];
   assign mem_lane = pop ? head[LANE_N*LANE_W +: LANE_N] : '0;

   ssc_mem #(
      .AW    (AW),
      .LW    (LANE_W),
      .LANES (LANE_N)
   ) u_mem (
      .mclk_in     (mclk_in),
      .wr_lane_in  (mem_lane),
      .wr_addr_in  (head[EW-1 -: AW]),
      .wr_data_in  (head[LANE_N*LANE_W-1:0]),
      .rd_en_in    (rd_en),
      .rd_addr_in  (addr_d),
      .rd_data_out (rd_data)
   );

   generate
      for (genvar j = 0; j < LANE_N; j++) begin : g_unpack
         assign dq_out[j*LANE_DQ_W +: LANE_DQ_W] = rd_data[j*LANE_W +: LANE_DQ_W];
         assign bidir_parity_pins_out[j]         = rd_data[j*LANE_W + LANE_DQ_W];
      end
   endgenerate

   // checks
   stall_hold_a : assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      !qual |=> $stable(op_q) && $stable(addr_q) && $stable(cnt_q))
      else $error("state moved on an unqualified edge");
   no_deselect_a : assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (clock_qualify_n_in && op_q != SSC_IDLE) |=> op_q != SSC_IDLE)
      else $error("clock qualify deselected the device");
   load_addr_a : assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (qual && !advance_or_load_in) |=> addr_q == $past(addr_in) && cnt_q == BURST_RST)
      else $error("load did not take the presented address");
   advance_cnt_a : assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (qual && advance_or_load_in) |=> cnt_q == $past(cnt_q) + BURST_ONE
      && addr_q[AW-1:BURST_W] == $past(addr_q[AW-1:BURST_W]))
      else $error("advance did not step the counter");
   burst_low_a : assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      addr_q[BURST_W-1:0] == ((order_q == ORDER_LINEAR) ? base_q + cnt_q
                                                       : base_q ^ cnt_q))
      else $error("burst low bits wrong");
   select_decode_a : assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (qual && !advance_or_load_in && !sel_now) |=> op_q == SSC_IDLE)
      else $error("deselect combination did not deselect");
   write_float_a : assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (op_q == SSC_WRITE || op_q == SSC_IDLE) |-> dq_oe_n_out)
      else $error("pins driven in write data phase or deselected");
   emerge_float_a : assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (qual && op_q == SSC_IDLE) ##1 1'b1 |-> dq_oe_n_out)
      else $error("pins driven on first clock after deselect");
   oe_high_float_a : assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (qual && output_enable_n_in) |=> dq_oe_n_out)
      else $error("pins driven with output enable high");
   wr_capture_a : assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (qual && op_q == SSC_WRITE) |-> push ##1 (cnt_b_q != CNT_ZERO))
      else $error("write data not captured");
endmodule : ssc_ctrl

// ### sim/ssc_host_model.sv
`timescale 1ns/1ps
module ssc_host_model
   import ssc_pkg::*;
#(
   parameter int W = ssc_pkg::DQ_W + ssc_pkg::LANE_N
) (
   // clock
   input  wire logic         mclk_in,
   // device and controller drivers
   input  wire logic [W-1:0] dev_data_in,
   input  wire logic         dev_oe_n_in,
   input  wire logic         host_drive_in,
   input  wire logic [W-1:0] host_data_in,
   // resolved pins
   output logic      [W-1:0] pin_out,
   output logic              clash_out
);
   logic [W-1:0] last_q;
   logic         clash_q = 1'b0;
   // no keeper on the pins: a floating bus shows the inverse of its last level
   assign pin_out = !dev_oe_n_in ? dev_data_in : host_drive_in ? host_data_in : ~last_q;
   assign clash_out = clash_q;
   always @(posedge mclk_in) begin
      last_q <= pin_out;
      if (!dev_oe_n_in && host_drive_in) begin
         clash_q <= 1'b1;
      end
   end
endmodule : ssc_host_model

// ### sim/ssc_ctrl_tb.sv
`timescale 1ns/1ps
module ssc_ctrl_tb;
   import ssc_pkg::*;
   localparam int W = DQ_W + LANE_N;
   logic              mclk_in = 1'b0;
   logic              rst = 1'b1;
   logic              qn = 1'b0;
   logic              we_n = 1'b1;
   logic              adv = 1'b0;
   logic              oe_n = 1'b0;
   logic              order = 1'b0;
   logic [2:0]        cs = 3'b000;
   logic [ADDR_W-1:0] addr = 20'h0_0000;
   logic [LANE_N-1:0] ln = 2'h3;
   logic              drv = 1'b0;
   logic              wr_op = 1'b0;
   logic [W-1:0]      wdat = 18'h0_0000;
   logic [W-1:0]      nxt_d = 18'h0_0000;
   logic [W-1:0]      pins;
   logic [DQ_W-1:0]   dq_o;
   logic [LANE_N-1:0] par_o;
   logic              oe_o;
   logic              rdy;
   logic              clash;
   int                fail_count = 0;
   int                n_checks = 0;

   initial begin
      forever #(CLK_NS / 2) mclk_in = ~mclk_in;
   end

   ssc_ctrl i_dut (.mclk_in(mclk_in), .sys_rst_in(rst), .clk_en_in(1'b1),
      .clock_qualify_n_in(qn), .addr_in(addr), .lane_write_select_n_in(ln),
      .write_strobe_n_in(we_n), .advance_or_load_in(adv), .select_low_first_n_in(cs[2]),
      .select_high_second_in(cs[1]), .select_low_third_n_in(cs[0]),
      .output_enable_n_in(oe_n), .burst_order_in(order), .dq_in(pins[DQ_W-1:0]),
      .bidir_parity_pins_in(pins[W-1:DQ_W]), .dq_out(dq_o), .bidir_parity_pins_out(par_o),
      .dq_oe_n_out(oe_o), .wbuf_ready_out(rdy));

   ssc_host_model i_host (.mclk_in(mclk_in), .dev_data_in({par_o, dq_o}),
      .dev_oe_n_in(oe_o), .host_drive_in(drv), .host_data_in(wdat), .pin_out(pins),
      .clash_out(clash));

   task close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out

   task chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task reset_dut(input logic o);
      @(posedge mclk_in);
      #1;
      order = o;
      rst = 1'b1;
      cs = 3'b000;
      adv = 1'b0;
      qn = 1'b0;
      drv = 1'b0;
      wr_op = 1'b0;
      repeat (8) @(posedge mclk_in);
      #1;
      rst = 1'b0;
   endtask : reset_dut

   // write data goes out in the cycle after its command edge
   task cmd(input logic [2:0] c, input logic w, a, input logic [ADDR_W-1:0] ad,
            input logic [LANE_N-1:0] l, input logic [W-1:0] d);
      @(posedge mclk_in);
      #1;
      drv = wr_op;
      wdat = nxt_d;
      qn = 1'b0;
      cs = c;
      we_n = w;
      adv = a;
      addr = ad;
      ln = l;
      wr_op = a ? wr_op : (c == 3'b010 && !w);
      nxt_d = d;
   endtask : cmd

   task rd(input logic [ADDR_W-1:0] ad);
      cmd(3'b010, 1'b1, 1'b0, ad, 2'b00, 18'h0_0000);
   endtask : rd

   task nx(input logic [W-1:0] d);
      cmd(3'b010, 1'b1, 1'b1, 20'h0_0000, 2'b00, d);
   endtask : nx

   task s_write(input logic [LANE_N-1:0] l, input logic [W-1:0] d, e);
      rd(20'h0_0104);
      cmd(3'b010, 1'b0, 1'b0, 20'h0_0104, l, d);
      rd(20'h0_0200);
      chk(W'(oe_o), 18'h0_0001);
      chk(W'(rdy), 18'h0_0001);
      rd(20'h0_0200);
      rd(20'h0_0104);
      rd(20'h0_0200);
      chk({par_o, dq_o}, e);
      chk(W'(oe_o), 18'h0_0000);
   endtask : s_write

   task s_desel;
      logic [2:0] bad [3];
      bad = '{3'b110, 3'b000, 3'b011};
      foreach (bad[i]) begin
         cmd(bad[i], 1'b1, 1'b0, 20'h0_0104, 2'b00, 18'h0_0000);
         rd(20'h0_0104);
         chk(W'(oe_o), 18'h0_0001);
         rd(20'h0_0104);
         chk(W'(oe_o), 18'h0_0001);
         rd(20'h0_0104);
         chk({par_o, dq_o}, 18'h1_23FF);
      end
      oe_n = 1'b1;
      rd(20'h0_0104);
      chk(W'(oe_o), 18'h0_0001);
      oe_n = 1'b0;
      rd(20'h0_0104);
      chk(W'(oe_o), 18'h0_0000);
   endtask : s_desel

   task s_burst(input logic o);
      logic [1:0] k;
      reset_dut(o);
      if (!o) begin
         cmd(3'b010, 1'b0, 1'b0, 20'h0_0040, 2'b00, 18'h0_0100);
         nx(18'h0_0101);
         nx(18'h0_0102);
         nx(18'h0_0103);
      end
      rd(20'h0_0041);
      rd(20'h0_0041);
      for (int i = 0; i < 4; i++) begin
         k = o ? 2'(1 ^ i) : 2'(1 + i);
         nx(18'h0_0000);
         chk({par_o, dq_o}, 18'h0_0100 + W'(k));
         if (i == 1) begin
            qn = 1'b1;
            repeat (3) @(posedge mclk_in);
            #1;
            chk({par_o, dq_o}, 18'h0_0100 + W'(k));
            chk(W'(oe_o), 18'h0_0000);
            qn = 1'b0;
         end
      end
   endtask : s_burst

   initial begin
      #(CLK_NS * 100000);
      fail_count++;
      close_out();
   end

   initial begin
      reset_dut(1'b0);
      s_write(2'b00, 18'h1_2345, 18'h1_2345);
      s_write(2'b10, 18'h3_FFFF, 18'h1_23FF);
      s_write(2'b11, 18'h0_0000, 18'h1_23FF);
      s_desel();
      s_burst(1'b0);
      s_burst(1'b1);
      chk(W'(clash), 18'h0_0000);
      close_out();
   end
endmodule : ssc_ctrl_tb
